//--- asf_defs.svh
// offsets, field positions, reset values and codes of the sticky flag block
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ASF_OFF_CORE_STATUS 8'h00
`define ASF_OFF_INT_STATUS  8'h04
`define ASF_OFF_INT_MASK    8'h08

// ---------------------------------------------------------------
// core_status field positions
// ---------------------------------------------------------------
`define ASF_BIT_LIMIT    6
`define ASF_BIT_SCALING  7
`define ASF_BIT_IPL_LO   8
`define ASF_BIT_IPL_HI   9
`define ASF_CORE_WIDTH   24

// ---------------------------------------------------------------
// interrupt event bits
// ---------------------------------------------------------------
`define ASF_EV_SCALING   0
`define ASF_EV_LIMIT     1
`define ASF_EV_WIDTH     2

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define ASF_RST_IPL      2'h3
`define ASF_RST_SCALING  1'h0
`define ASF_RST_LIMIT    1'h0
`define ASF_RST_MASK     2'h0
`define ASF_MODE_NONE    2'h0
`define ASF_MODE_DOWN    2'h1
`define ASF_MODE_UP      2'h2
`define ASF_RESP_OKAY    2'h0
`define ASF_RESP_SLVERR  2'h2

`endif

//--- asf_pkg.sv
// types shared by the sticky flag block
package asf_pkg;
  typedef logic [1:0]  asf_mode_t;
  typedef logic [55:0] asf_acc_t;
  typedef enum {WR_IDLE, WR_ADDR, WR_DATA, WR_RESP} asf_wr_e;
endpackage

//--- asf_flag_if.sv
// evaluator signals between the flag core and its two evaluators
`timescale 1ns/100ps
interface asf_flag_if;
  asf_pkg::asf_mode_t scale_mode;
  asf_pkg::asf_acc_t  acc [2];
  logic               overflow;
  logic               limiting;
  logic               saturated;
  logic               sat_mode;
  logic               scale_hit;
  logic               limit_hit;

  modport core  (output scale_mode, acc, overflow, limiting, saturated, sat_mode,
                 input scale_hit, limit_hit);
  modport scale (input scale_mode, acc, output scale_hit);
  modport limit (input overflow, limiting, saturated, sat_mode, output limit_hit);
endinterface

//--- asf_scale_eval.sv
// scaling flag equation selected by the scaling mode
`timescale 1ns/100ps
`include "asf_defs.svh"
module asf_scale_eval (
  asf_flag_if.scale f  // evaluator side
);
  logic [1:0] hit;

  // one bit pair per accumulator, pair chosen by mode
  for (genvar g = 0; g < 2; g++) begin : g_acc
    always_comb begin
      case (f.scale_mode)
        `ASF_MODE_NONE: hit[g] = f.acc[g][46] ^ f.acc[g][45];
        `ASF_MODE_DOWN: hit[g] = f.acc[g][47] ^ f.acc[g][46];
        `ASF_MODE_UP:   hit[g] = f.acc[g][45] ^ f.acc[g][44];
        default:        hit[g] = 1'b0; // reserved code: flag holds
      endcase
    end
  end

  // either accumulator sets the flag
  assign f.scale_hit = |hit;
endmodule

//--- asf_limit_eval.sv
// limit flag set condition
`timescale 1ns/100ps
module asf_limit_eval (
  asf_flag_if.limit f  // evaluator side
);
  // overflow, limiter action, or saturation in saturation mode
  assign f.limit_hit = f.overflow | f.limiting
                     | (f.sat_mode & f.saturated);
endmodule

//--- asf_top.sv
// sticky scaling and limit flags, interrupt mask field and register slave
`timescale 1ns/100ps
`include "asf_defs.svh"

// Notes on behaviour
// - accumulator move to data bus sets scaling
// - scaling flag sticky, cleared explicitly, resets zero
// - scaling mode picks the flag equation
// - overflow or limiter action sets limit
// - saturation sets limit only in saturation mode
// - limit flag latches, cleared by reset/instruction
// - accumulator reads by moves update limit
// - per-mode bit pairs, ORed with previous value
module asf_top #(
  parameter int ADDR_W = 8  // axi address width
) (
  input  wire logic               i_clk,            // core clock
  input  wire logic               i_sys_rst,        // sync reset, high
  input  wire logic               i_ce,             // clock enable
  input  wire logic [ADDR_W-1:0]  i_s_axi_awaddr,   // write address
  input  wire logic               i_s_axi_awvalid,  // write address valid
  output logic                    o_s_axi_awready,  // write address ready
  input  wire logic [31:0]        i_s_axi_wdata,    // write data
  input  wire logic [3:0]         i_s_axi_wstrb,    // write byte strobes
  input  wire logic               i_s_axi_wvalid,   // write data valid
  output logic                    o_s_axi_wready,   // write data ready
  output logic [1:0]              o_s_axi_bresp,    // write response
  output logic                    o_s_axi_bvalid,   // write response valid
  input  wire logic               i_s_axi_bready,   // write response ready
  input  wire logic [ADDR_W-1:0]  i_s_axi_araddr,   // read address
  input  wire logic               i_s_axi_arvalid,  // read address valid
  output logic                    o_s_axi_arready,  // read address ready
  output logic [31:0]             o_s_axi_rdata,    // read data
  output logic [1:0]              o_s_axi_rresp,    // read response
  output logic                    o_s_axi_rvalid,   // read data valid
  input  wire logic               i_s_axi_rready,   // read data ready
  input  wire asf_pkg::asf_mode_t i_scale_mode,     // scaling mode field
  input  wire asf_pkg::asf_acc_t  i_acc_a,          // accumulator a
  input  wire asf_pkg::asf_acc_t  i_acc_b,          // accumulator b
  input  wire logic               i_acc_move,       // a/b onto data bus
  input  wire logic               i_overflow,       // overflow flag set
  input  wire logic               i_limiting,       // limiter acted
  input  wire logic               i_saturated,      // alu result saturated
  input  wire logic               i_sat_mode,       // saturation mode on
  input  wire logic               i_clr_scaling,    // instruction clears s
  input  wire logic               i_clr_limit,      // instruction clears l
  output logic                    o_scaling_flag,   // sticky scaling flag
  output logic                    o_limit_flag,     // sticky limit flag
  output logic [1:0]              o_interrupt_priority_level, // mask field
  output logic [3:0]              o_level_permit,   // levels let through
  output logic                    o_irq             // interrupt, high
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
    $error("asf_top: ADDR_W must lie in 4..32");
  end

  // ---------------------------------------------------------------
  // evaluators
  // ---------------------------------------------------------------
  asf_flag_if flag_bus ();

  // drive evaluator inputs from the core pins
  assign flag_bus.scale_mode = i_scale_mode;
  assign flag_bus.acc[0]     = i_acc_a;
  assign flag_bus.acc[1]     = i_acc_b;
  assign flag_bus.overflow   = i_overflow;
  assign flag_bus.limiting   = i_limiting;
  assign flag_bus.saturated  = i_saturated;
  assign flag_bus.sat_mode   = i_sat_mode;

  asf_scale_eval u_scale (
    .f (flag_bus.scale)
  );

  asf_limit_eval u_limit (
    .f (flag_bus.limit)
  );

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  asf_pkg::asf_wr_e        wr_st_q, wr_st_d;
  logic [ADDR_W-1:0]       awaddr_q, awaddr_d;
  logic [31:0]             wdata_q, wdata_d;
  logic [3:0]              wstrb_q, wstrb_d;
  logic                    awready_q, awready_d;
  logic                    wready_q, wready_d;
  logic                    bvalid_q, bvalid_d;
  logic [1:0]              bresp_q, bresp_d;
  logic                    arready_q, arready_d;
  logic                    rvalid_q, rvalid_d;
  logic [31:0]             rdata_q, rdata_d;
  logic [1:0]              rresp_q, rresp_d;
  logic                    scal_q, scal_d;
  logic                    lim_q, lim_d;
  logic [1:0]              ipl_q, ipl_d;
  logic [3:0]              permit_q, permit_d;
  logic [`ASF_EV_WIDTH-1:0] ist_q, ist_d;
  logic [`ASF_EV_WIDTH-1:0] imask_q, imask_d;
  logic                    irq_q, irq_d;

  // ---------------------------------------------------------------
  // write channel handling
  // ---------------------------------------------------------------
  logic              aw_hs;
  logic              w_hs;
  logic              commit;
  logic [ADDR_W-1:0] eff_addr;
  logic [31:0]       eff_data;
  logic [3:0]        eff_strb;
  logic [7:0]        eff_off;
  logic              wr_core;
  logic              wr_ist;
  logic              wr_imask;

  // handshakes on this edge
  assign aw_hs = i_s_axi_awvalid & awready_q;
  assign w_hs  = i_s_axi_wvalid & wready_q;

  // address and data either taken now or held from earlier
  assign eff_addr = aw_hs ? i_s_axi_awaddr : awaddr_q;
  assign eff_data = w_hs ? i_s_axi_wdata : wdata_q;
  assign eff_strb = w_hs ? i_s_axi_wstrb : wstrb_q;
  assign eff_off  = 8'(eff_addr & ADDR_W'(8'hfc));

  // write state and channel readies
  always_comb begin
    wr_st_d  = wr_st_q;
    awaddr_d = aw_hs ? i_s_axi_awaddr : awaddr_q;
    wdata_d  = w_hs ? i_s_axi_wdata : wdata_q;
    wstrb_d  = w_hs ? i_s_axi_wstrb : wstrb_q;
    commit   = 1'b0;
    case (wr_st_q)
      asf_pkg::WR_IDLE: begin
        if (aw_hs && w_hs) begin
          commit  = 1'b1;
          wr_st_d = asf_pkg::WR_RESP;
        end else if (aw_hs) begin
          wr_st_d = asf_pkg::WR_ADDR;
        end else if (w_hs) begin
          wr_st_d = asf_pkg::WR_DATA;
        end
      end
      asf_pkg::WR_ADDR: begin
        if (w_hs) begin
          commit  = 1'b1;
          wr_st_d = asf_pkg::WR_RESP;
        end
      end
      asf_pkg::WR_DATA: begin
        if (aw_hs) begin
          commit  = 1'b1;
          wr_st_d = asf_pkg::WR_RESP;
        end
      end
      asf_pkg::WR_RESP: begin
        if (i_s_axi_bready) begin
          wr_st_d = asf_pkg::WR_IDLE;
        end
      end
      default: wr_st_d = asf_pkg::WR_IDLE;
    endcase
    awready_d = (wr_st_d == asf_pkg::WR_IDLE) || (wr_st_d == asf_pkg::WR_DATA);
    wready_d  = (wr_st_d == asf_pkg::WR_IDLE) || (wr_st_d == asf_pkg::WR_ADDR);
    bvalid_d  = (wr_st_d == asf_pkg::WR_RESP);
  end

  // write decode and response code
  always_comb begin
    wr_core  = commit && (eff_off == `ASF_OFF_CORE_STATUS);
    wr_ist   = commit && (eff_off == `ASF_OFF_INT_STATUS);
    wr_imask = commit && (eff_off == `ASF_OFF_INT_MASK);
    bresp_d  = bresp_q;
    if (commit) begin
      bresp_d = (wr_core || wr_ist || wr_imask) ? `ASF_RESP_OKAY : `ASF_RESP_SLVERR;
    end
  end

  // ---------------------------------------------------------------
  // read channel handling
  // ---------------------------------------------------------------
  logic       ar_hs;
  logic [7:0] ar_off;

  assign ar_hs  = i_s_axi_arvalid & arready_q;
  assign ar_off = 8'(i_s_axi_araddr & ADDR_W'(8'hfc));

  // read data capture, one read at a time
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && i_s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_hs) begin
      rvalid_d = 1'b1;
      rresp_d  = `ASF_RESP_OKAY;
      case (ar_off)
        `ASF_OFF_CORE_STATUS: begin
          rdata_d = 32'h0000_0000;
          rdata_d[`ASF_BIT_IPL_HI:`ASF_BIT_IPL_LO] = ipl_q;
          rdata_d[`ASF_BIT_SCALING] = scal_q;
          rdata_d[`ASF_BIT_LIMIT]   = lim_q;
        end
        `ASF_OFF_INT_STATUS: rdata_d = {30'h0, ist_q};
        `ASF_OFF_INT_MASK:   rdata_d = {30'h0, imask_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `ASF_RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // ---------------------------------------------------------------
  // sticky flags and mask field
  // ---------------------------------------------------------------
  logic sw_clr_scal;
  logic sw_clr_lim;
  logic scal_set;
  logic lim_set;

  // software clears by writing zero into the low byte
  assign sw_clr_scal = wr_core && eff_strb[0] && !eff_data[`ASF_BIT_SCALING];
  assign sw_clr_lim  = wr_core && eff_strb[0] && !eff_data[`ASF_BIT_LIMIT];

  // set terms: mode-selected equation on a bus move
  assign scal_set = i_acc_move && flag_bus.scale_hit;
  // limit events, including those seen during accumulator moves
  assign lim_set  = flag_bus.limit_hit;

  // flag update: clear first, set wins over the clear
  always_comb begin
    scal_d = scal_q;
    lim_d  = lim_q;
    if (i_clr_scaling || sw_clr_scal) begin
      scal_d = 1'b0;
    end
    if (i_clr_limit || sw_clr_lim) begin
      lim_d = 1'b0;
    end
    scal_d = scal_d | scal_set;
    lim_d  = lim_d | lim_set;
  end

  // interrupt priority mask field and permitted levels
  always_comb begin
    ipl_d = ipl_q;
    if (wr_core && eff_strb[1]) begin
      ipl_d = eff_data[`ASF_BIT_IPL_HI:`ASF_BIT_IPL_LO];
    end
  end

  // a level passes when it is at or above the mask field
  for (genvar k = 0; k < 4; k++) begin : g_permit
    assign permit_d[k] = (2'(k) >= ipl_d);
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  always_comb begin
    ist_d   = ist_q;
    imask_d = imask_q;
    if (wr_ist && eff_strb[0]) begin
      ist_d = ist_q & ~eff_data[`ASF_EV_WIDTH-1:0];
    end
    if (wr_imask && eff_strb[0]) begin
      imask_d = eff_data[`ASF_EV_WIDTH-1:0];
    end
    // new flag rises are events; they win over a clear
    ist_d[`ASF_EV_SCALING] = ist_d[`ASF_EV_SCALING] | (scal_d & !scal_q);
    ist_d[`ASF_EV_LIMIT]   = ist_d[`ASF_EV_LIMIT] | (lim_d & !lim_q);
    irq_d = |(ist_d & imask_d);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_st_q   <= asf_pkg::WR_IDLE;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `ASF_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `ASF_RESP_OKAY;
      scal_q    <= `ASF_RST_SCALING;
      lim_q     <= `ASF_RST_LIMIT;
      ipl_q     <= `ASF_RST_IPL;
      permit_q  <= 4'h8;
      ist_q     <= '0;
      imask_q   <= `ASF_RST_MASK;
      irq_q     <= 1'b0;
    end else if (i_ce) begin
      wr_st_q   <= wr_st_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      scal_q    <= scal_d;
      lim_q     <= lim_d;
      ipl_q     <= ipl_d;
      permit_q  <= permit_d;
      ist_q     <= ist_d;
      imask_q   <= imask_d;
      irq_q     <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign o_s_axi_awready            = awready_q;
  assign o_s_axi_wready             = wready_q;
  assign o_s_axi_bvalid             = bvalid_q;
  assign o_s_axi_bresp              = bresp_q;
  assign o_s_axi_arready            = arready_q;
  assign o_s_axi_rvalid             = rvalid_q;
  assign o_s_axi_rdata              = rdata_q;
  assign o_s_axi_rresp              = rresp_q;
  assign o_scaling_flag             = scal_q;
  assign o_limit_flag               = lim_q;
  assign o_interrupt_priority_level = ipl_q;
  assign o_level_permit             = permit_q;
  assign o_irq                      = irq_q;

endmodule

//--- asf_checker.sv
// property checks on the sticky flag block ports
`timescale 1ns/100ps
module asf_checker (
  input wire logic               i_clk,           // clock
  input wire logic               i_sys_rst,       // reset
  input wire logic               i_ce,            // enable
  input wire logic               i_s_axi_awvalid, // aw valid
  input wire logic               i_s_axi_wvalid,  // w valid
  input wire asf_pkg::asf_mode_t i_scale_mode,    // mode
  input wire asf_pkg::asf_acc_t  i_acc_a,         // acc a
  input wire asf_pkg::asf_acc_t  i_acc_b,         // acc b
  input wire logic               i_acc_move,      // move
  input wire logic               i_overflow,      // overflow
  input wire logic               i_limiting,      // limiter
  input wire logic               i_saturated,     // saturated
  input wire logic               i_sat_mode,      // sat mode
  input wire logic               i_clr_scaling,   // clear s
  input wire logic               i_clr_limit,     // clear l
  input wire logic               o_scaling_flag,  // scaling
  input wire logic               o_limit_flag,    // limit
  input wire logic [1:0]         o_interrupt_priority_level, // mask
  input wire logic [3:0]         o_level_permit   // permits
);
  // ----------
  // clocking
  // ----------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst || !i_ce);

  // no cause for the limit flag this cycle
  sequence s_quiet_l;
    !o_limit_flag && !i_overflow && !i_limiting && !(i_saturated && i_sat_mode);
  endsequence

  // ----------
  // properties
  // ----------
  AST_SC_NONE: assert property (i_acc_move && i_scale_mode == 2'h0 &&
    (i_acc_a[46] ^ i_acc_a[45] || i_acc_b[46] ^ i_acc_b[45]) |=> o_scaling_flag)
    else $error("scaling not set, no scaling mode");
  AST_SC_DOWN: assert property (i_acc_move && i_scale_mode == 2'h1 &&
    (i_acc_a[47] ^ i_acc_a[46] || i_acc_b[47] ^ i_acc_b[46]) |=> o_scaling_flag)
    else $error("scaling not set, scale down");
  AST_SC_UP: assert property (i_acc_move && i_scale_mode == 2'h2 &&
    (i_acc_a[45] ^ i_acc_a[44] || i_acc_b[45] ^ i_acc_b[44]) |=> o_scaling_flag)
    else $error("scaling not set, scale up");
  AST_SC_NOMOVE: assert property (!i_acc_move && !o_scaling_flag |=> !o_scaling_flag)
    else $error("scaling set without a move");
  AST_SC_HOLD: assert property (o_scaling_flag && !i_clr_scaling && !i_s_axi_wvalid
    && !i_s_axi_awvalid |=> o_scaling_flag)
    else $error("scaling flag dropped");
  AST_LIM_SET: assert property (i_overflow || i_limiting |=> o_limit_flag)
    else $error("limit not set");
  AST_LIM_SAT: assert property (i_saturated && i_sat_mode |=> o_limit_flag)
    else $error("limit not set on saturation");
  AST_LIM_QUIET: assert property (s_quiet_l |=> !o_limit_flag)
    else $error("limit set without cause");
  AST_LIM_HOLD: assert property (o_limit_flag && !i_clr_limit && !i_s_axi_wvalid
    && !i_s_axi_awvalid |=> o_limit_flag)
    else $error("limit flag dropped");
  AST_PERMIT: assert property ($stable(o_interrupt_priority_level) |->
    o_level_permit == (4'hf << o_interrupt_priority_level))
    else $error("level permit wrong");
  AST_RST: assert property (@(posedge i_clk) disable iff (1'b0) i_sys_rst |=>
    o_interrupt_priority_level == 2'h3 && !o_scaling_flag && !o_limit_flag)
    else $error("reset values wrong");
endmodule

//--- asf_top_tb.sv
// self-checking bench for the sticky flag block
`timescale 1ns/100ps
module asf_top_tb;
  logic i_clk, i_sys_rst, i_ce, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic i_s_axi_arvalid, i_s_axi_rready, i_acc_move, i_overflow, i_limiting;
  logic i_saturated, i_sat_mode, i_clr_scaling, i_clr_limit, o_irq;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_scaling_flag, o_limit_flag;
  logic [7:0]         i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0]        i_s_axi_wdata, o_s_axi_rdata;
  logic [3:0]         i_s_axi_wstrb, o_level_permit;
  logic [1:0]         o_s_axi_bresp, o_s_axi_rresp, o_interrupt_priority_level;
  asf_pkg::asf_mode_t i_scale_mode;
  asf_pkg::asf_acc_t  i_acc_a, i_acc_b;
  int                 failures, check_count, seed, cyc_n, m_s, m_l, m_ipl, m_st, m_mk;

  asf_top u_dut (.i_clk, .i_sys_rst, .i_ce, .i_s_axi_awaddr, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
    .i_scale_mode, .i_acc_a, .i_acc_b, .i_acc_move, .i_overflow, .i_limiting, .i_saturated,
    .i_sat_mode, .i_clr_scaling, .i_clr_limit, .o_scaling_flag, .o_limit_flag,
    .o_interrupt_priority_level, .o_level_permit, .o_irq);

  // ----------
  // helpers
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // register write, model follows the register map
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_wstrb <= s;
    i_s_axi_awvalid <= 1;
    i_s_axi_wvalid <= 1;
    i_s_axi_bready <= 1;
    do begin
      @(posedge i_clk);
      if (!aw && o_s_axi_awready) begin
        aw = 1;
        i_s_axi_awvalid <= 0;
      end
      if (!w && o_s_axi_wready) begin
        w = 1;
        i_s_axi_wvalid <= 0;
      end
    end while (!(aw && w));
    do @(posedge i_clk); while (o_s_axi_bvalid !== 1'b1);
    i_s_axi_bready <= 0;
    chk("bresp", o_s_axi_bresp, (a < 8'h0c) ? 0 : 2);
    if (a == 8'h00 && s[0] && !d[7]) m_s = 0;
    if (a == 8'h00 && s[0] && !d[6]) m_l = 0;
    if (a == 8'h00 && s[1]) m_ipl = d[9:8];
    if (a == 8'h04) m_st = m_st & ~d[1:0];
    if (a == 8'h08) m_mk = d[1:0];
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1;
    i_s_axi_rready <= 1;
    do @(posedge i_clk); while (o_s_axi_arready !== 1'b1);
    i_s_axi_arvalid <= 0;
    do @(posedge i_clk); while (o_s_axi_rvalid !== 1'b1);
    i_s_axi_rready <= 0;
    chk("rdata", o_s_axi_rdata, exp);
    chk("rresp", o_s_axi_rresp, (a < 8'h0c) ? 0 : 2);
  endtask

  // one random alu cycle, model and compare
  task automatic ev();
    logic [1:0] md;
    asf_pkg::asf_acc_t a, b;
    logic [6:0] c;
    int hs, hl;
    md = 2'($random(seed));
    a = 56'({$random(seed), $random(seed)});
    b = 56'({$random(seed), $random(seed)});
    c = 7'($random(seed) & $random(seed));
    case (md)
      2'h0: hs = (a[46] ^ a[45]) | (b[46] ^ b[45]);
      2'h1: hs = (a[47] ^ a[46]) | (b[47] ^ b[46]);
      2'h2: hs = (a[45] ^ a[44]) | (b[45] ^ b[44]);
      default: hs = 0;
    endcase
    hs = hs & c[0];
    hl = c[1] | c[2] | (c[3] & c[4]);
    if (hs && !m_s) m_st = m_st | 1;
    if (hl && !m_l) m_st = m_st | 2;
    m_s = hs ? 1 : (c[5] ? 0 : m_s);
    m_l = hl ? 1 : (c[6] ? 0 : m_l);
    @(posedge i_clk);
    {i_clr_limit, i_clr_scaling, i_sat_mode, i_saturated, i_limiting, i_overflow} <= c[6:1];
    i_acc_move <= c[0];
    i_scale_mode <= md;
    i_acc_a <= a;
    i_acc_b <= b;
    @(posedge i_clk);
    {i_clr_limit, i_clr_scaling, i_saturated, i_limiting, i_overflow, i_acc_move} <= 6'h00;
    #1;
    chk("scaling", o_scaling_flag, m_s);
    chk("limit", o_limit_flag, m_l);
    chk("irq", o_irq, (m_st & m_mk) != 0);
  endtask

  // ----------
  // clock, timeout and bind
  // ----------
  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end

  // hang guard
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      failures++;
      end_of_test();
    end
  end

  // main sequence
  initial begin
    {i_ce, i_sys_rst} = 2'h3;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = 0;
    {i_acc_move, i_overflow, i_limiting, i_saturated, i_sat_mode} = 0;
    {i_clr_scaling, i_clr_limit, i_scale_mode, i_acc_a, i_acc_b} = 0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_wstrb} = 0;
    {failures, check_count, cyc_n, m_s, m_l, m_st, m_mk} = 0;
    m_ipl = 3;
    seed = 18;
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 0;
    #1;
    chk("permit", o_level_permit, 4'h8);
    rd_chk(8'h00, 32'h300);
    rd_chk(8'h04, 0);
    rd_chk(8'h08, 0);
    rd_chk(8'h0c, 0);
    wr(8'h10, 32'hffffffff, 4'hf);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 32'h0c0 | (k << 8), 4'h3);
      @(posedge i_clk);
      #1;
      chk("permit", o_level_permit, 4'(4'hf << k));
      rd_chk(8'h00, (m_ipl << 8) | (m_s << 7) | (m_l << 6));
    end
    $display("test mask done");
    for (int n = 0; n < 150; n++) begin
      if (n % 15 == 0) begin
        wr(8'h08, $random(seed) & 3, 4'h1);
        wr(8'h04, $random(seed) & 3, 4'h1);
        wr(8'h00, $random(seed) & 32'h3c0, 4'h1);
        rd_chk(8'h04, m_st);
        rd_chk(8'h00, (m_ipl << 8) | (m_s << 7) | (m_l << 6));
      end
      ev();
    end
    $display("test flags done");
    // enable held low: a pending overflow waits for it
    wr(8'h00, 32'h080, 4'h3);
    @(posedge i_clk);
    i_ce <= 0;
    i_overflow <= 1;
    repeat (3) @(posedge i_clk);
    i_ce <= 1;
    #1;
    chk("frozen limit", o_limit_flag, m_l);
    @(posedge i_clk);
    i_overflow <= 0;
    m_st = m_st | 2;
    m_l = 1;
    #1;
    chk("limit", o_limit_flag, m_l);
    chk("irq", o_irq, (m_st & m_mk) != 0);
    // mid-run reset brings back the reset values
    @(posedge i_clk);
    i_sys_rst <= 1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 0;
    {m_s, m_l, m_st, m_mk} = 0;
    m_ipl = 3;
    #1;
    chk("permit", o_level_permit, 4'h8);
    chk("irq", o_irq, 0);
    rd_chk(8'h00, 32'h300);
    rd_chk(8'h04, 0);
    $display("test enable and reset done");
    end_of_test();
  end
endmodule

bind asf_top asf_checker u_chk (.i_clk, .i_sys_rst, .i_ce, .i_s_axi_awvalid,
  .i_s_axi_wvalid, .i_scale_mode,
  .i_acc_a, .i_acc_b, .i_acc_move, .i_overflow, .i_limiting, .i_saturated, .i_sat_mode,
  .i_clr_scaling, .i_clr_limit, .o_scaling_flag, .o_limit_flag,
  .o_interrupt_priority_level, .o_level_permit);
